/* fpd_params.svh */
// constants for the five-port pin configuration block
// assumes a 32-bit avalon-mm slave with word-aligned byte addresses
`ifndef FPD_PARAMS_SVH
`define FPD_PARAMS_SVH
// register byte offsets
`define FPD_DIRS_OFF 8'h00
`define FPD_TRIS_OFF 8'h04
`define FPD_OUTC_OFF 8'h08
`define FPD_LINE_OFF 8'h0c
`define FPD_FUNC_OFF 8'h10
`define FPD_OUTB_OFF 8'h14
`define FPD_TEST_OFF 8'h18
`define FPD_INS_OFF 8'h1c
`define FPD_ANA_OFF 8'h20
// line command field positions
`define FPD_LINE_NUM_LSB 0
`define FPD_LINE_LVL_BIT 4
// function register bit positions
`define FPD_FUNC_PWM1 0
`define FPD_FUNC_PWM2 1
`define FPD_FUNC_I2C 2
`define FPD_FUNC_PA_DIG 3
// level test fields
`define FPD_TEST_MASK_LSB 0
`define FPD_TEST_VAL_LSB 8
`define FPD_TEST_PORT_LSB 16
`define FPD_TEST_ALL_BIT 18
// reset values
`define FPD_DIRS_RST 8'h00
`define FPD_OUT_RST 8'h00
`define FPD_FUNC_RST 4'h0
`define FPD_ANA_MODE_RST 3'h7
// automatic hardware refresh period of the hardware direction register, in cycles
`define FPD_REFRESH_CYC 8'd64
`endif

/* fpd_pkg.sv */
// types for the five-port pin configuration block
// assumes fpd_params.svh supplies the numeric constants
package fpd_pkg;
    // port selector used by the level test
    typedef enum logic [1:0] {
        FPD_SEL_STD,
        FPD_SEL_ANA,
        FPD_SEL_BIDIR,
        FPD_SEL_NONE
    } fpd_port_e;
    // bus slave state
    typedef enum logic [0:0] {
        FPD_IDLE,
        FPD_DONE
    } fpd_bus_e;
endpackage

/* fpd_pin_config.sv */
// five-port pin direction and function logic with an avalon-mm register slave
// assumes pin inputs are synchronous to core_clk; board resolves pin wires
`include "fpd_params.svh"
module fpd_pin_config
    import fpd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic [1:0] response,
    input wire logic [3:0] ana_port_in,
    output logic ana_port_digital,
    output logic [7:0] fixed_output_port,
    input wire logic [7:0] bidir_in,
    output logic [7:0] bidir_out,
    output logic [7:0] bidir_oe,
    input wire logic [7:0] standard_input_port,
    output logic ir_rx,
    output logic kbd_clk,
    output logic kbd_data,
    input wire logic [2:0] fixed_ana_in,
    output logic [2:0] fixed_ana_mode,
    input wire logic pwm1_in,
    input wire logic pwm2_in,
    input wire logic scl_out,
    input wire logic sda_out,
    output logic scl_in,
    output logic sda_in
);
    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0] dirs_reg;
    logic [7:0] hw_tris_reg;
    logic [7:0] outc_reg;
    logic [7:0] outb_reg;
    logic [3:0] func_reg;
    logic [7:0] refresh_reg;
    logic test_reg;
    fpd_bus_e bus_reg;
    logic wr_hit;
    logic [7:0] be_mask;
    logic [7:0] wbyte;
    logic [2:0] line_num;
    logic [7:0] pinv;
    logic [7:0] tmask;
    logic [7:0] tval;
    fpd_port_e tport;
    logic tres;

    // a write lands once, on the answer cycle
    assign wr_hit = write && (bus_reg == FPD_DONE);
    assign be_mask = byteenable[0] ? 8'hff : 8'h00;
    assign wbyte = writedata[7:0];
    assign line_num = writedata[`FPD_LINE_NUM_LSB +: 3];

    // ------------------------------------------------------------
    // bus slave: one wait cycle, answer on the second
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bus_reg <= FPD_IDLE;
        end else if (bus_reg == FPD_IDLE && (read || write)) begin
            bus_reg <= FPD_DONE;
        end else begin
            bus_reg <= FPD_IDLE;
        end
    end

    // waitrequest is low only during the answer cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !(bus_reg == FPD_IDLE && (read || write));
        end
    end

    // ------------------------------------------------------------
    // direction setting and single-line commands
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dirs_reg <= `FPD_DIRS_RST;
        end else if (wr_hit && address == `FPD_DIRS_OFF) begin
            dirs_reg <= (dirs_reg & ~be_mask) | (wbyte & be_mask);
        end else if (wr_hit && address == `FPD_TRIS_OFF) begin
            dirs_reg <= (dirs_reg & ~be_mask) | (~wbyte & be_mask);
        end else if (wr_hit && address == `FPD_LINE_OFF && byteenable[0]) begin
            dirs_reg[line_num] <= 1'b1;
        end
    end

    // output latch holds its value whatever the direction
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            outc_reg <= `FPD_OUT_RST;
        end else if (wr_hit && address == `FPD_OUTC_OFF) begin
            outc_reg <= (outc_reg & ~be_mask) | (wbyte & be_mask);
        end else if (wr_hit && address == `FPD_LINE_OFF && byteenable[0]) begin
            outc_reg[line_num] <= writedata[`FPD_LINE_LVL_BIT];
        end
    end

    // fixed output value and alternate function enables
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            outb_reg <= `FPD_OUT_RST;
            func_reg <= `FPD_FUNC_RST;
        end else begin
            if (wr_hit && address == `FPD_OUTB_OFF) begin
                outb_reg <= (outb_reg & ~be_mask) | (wbyte & be_mask);
            end
            if (wr_hit && address == `FPD_FUNC_OFF && byteenable[0]) begin
                func_reg <= writedata[3:0];
            end
        end
    end

    // ------------------------------------------------------------
    // periodic refresh of the hardware direction register
    // ------------------------------------------------------------
    // software cannot write it; a glitch on it heals within one period
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            refresh_reg <= 8'h00;
            hw_tris_reg <= ~`FPD_DIRS_RST;
        end else if (refresh_reg == `FPD_REFRESH_CYC - 8'd1) begin
            refresh_reg <= 8'h00;
            hw_tris_reg <= ~dirs_reg;
        end else begin
            refresh_reg <= refresh_reg + 8'd1;
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    // alternate functions override the latch on lines 1 to 4
    always_comb begin
        pinv = outc_reg;
        if (func_reg[`FPD_FUNC_PWM1]) pinv[1] = pwm1_in;
        if (func_reg[`FPD_FUNC_PWM2]) pinv[2] = pwm2_in;
        if (func_reg[`FPD_FUNC_I2C]) begin
            pinv[3] = 1'b0; // open drain
            pinv[4] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // two-way port drive values and enables
    // ------------------------------------------------------------
    // drive value comes from the latch or from an alternate source
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bidir_out <= `FPD_OUT_RST;
        end else begin
            bidir_out <= pinv;
        end
    end

    // enables follow the refreshed copy, not the stored setting, so a
    // direction write reaches the pins only after the next refresh
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bidir_oe <= 8'h00;
        end else begin
            bidir_oe <= ~hw_tris_reg;
            if (func_reg[`FPD_FUNC_PWM1]) bidir_oe[1] <= 1'b1;
            if (func_reg[`FPD_FUNC_PWM2]) bidir_oe[2] <= 1'b1;
            if (func_reg[`FPD_FUNC_I2C]) begin
                bidir_oe[3] <= !scl_out;
                bidir_oe[4] <= !sda_out;
            end
        end
    end

    // ------------------------------------------------------------
    // fixed output port
    // ------------------------------------------------------------
    // these lines have no enable at all, so no write can turn them round
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fixed_output_port <= `FPD_OUT_RST;
        end else begin
            fixed_output_port <= outb_reg;
        end
    end

    // ------------------------------------------------------------
    // analogue ports
    // ------------------------------------------------------------
    // analogue-capable port stays analogue until software asks otherwise
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ana_port_digital <= 1'b0;
        end else begin
            ana_port_digital <= func_reg[`FPD_FUNC_PA_DIG];
        end
    end

    // the three fixed lines ignore every register; the mode is a constant
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fixed_ana_mode <= `FPD_ANA_MODE_RST;
        end else begin
            fixed_ana_mode <= `FPD_ANA_MODE_RST;
        end
    end

    // ------------------------------------------------------------
    // shared input functions
    // ------------------------------------------------------------
    // infrared and keyboard inputs copy the standard port, one cycle late
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ir_rx <= 1'b0;
            kbd_clk <= 1'b0;
            kbd_data <= 1'b0;
        end else begin
            ir_rx <= standard_input_port[0];
            kbd_clk <= standard_input_port[6];
            kbd_data <= standard_input_port[7];
        end
    end

    // i2c inputs read the pad level; idle high like a pulled-up bus
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            scl_in <= 1'b1;
            sda_in <= 1'b1;
        end else begin
            scl_in <= bidir_in[3];
            sda_in <= bidir_in[4];
        end
    end

    // ------------------------------------------------------------
    // level test: one port per test, standard port by default
    // ------------------------------------------------------------
    assign tmask = writedata[`FPD_TEST_MASK_LSB +: 8];
    assign tval = writedata[`FPD_TEST_VAL_LSB +: 8];
    assign tport = fpd_port_e'(writedata[`FPD_TEST_PORT_LSB +: 2]);

    always_comb begin
        unique case (tport)
            FPD_SEL_STD: tres = writedata[`FPD_TEST_ALL_BIT]
                ? ((standard_input_port & tmask) == (tval & tmask))
                : |(~(standard_input_port ^ tval) & tmask);
            FPD_SEL_ANA: tres = writedata[`FPD_TEST_ALL_BIT]
                ? (({4'h0, ana_port_in} & tmask) == (tval & tmask))
                : |(~({4'h0, ana_port_in} ^ tval) & tmask & 8'h0f);
            FPD_SEL_BIDIR: tres = writedata[`FPD_TEST_ALL_BIT]
                ? ((bidir_in & tmask) == (tval & tmask))
                : |(~(bidir_in ^ tval) & tmask);
            FPD_SEL_NONE: tres = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            test_reg <= 1'b0;
        end else if (wr_hit && address == `FPD_TEST_OFF) begin
            test_reg <= tres;
        end
    end

    // ------------------------------------------------------------
    // read data and response
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            readdata <= 32'h0;
            response <= 2'h0;
        end else if (bus_reg == FPD_IDLE && (read || write)) begin
            response <= 2'h0;
            readdata <= 32'h0;
            unique case (address)
                `FPD_DIRS_OFF: readdata <= {24'h0, dirs_reg};
                `FPD_TRIS_OFF: readdata <= {24'h0, ~dirs_reg};
                `FPD_OUTC_OFF: readdata <= {24'h0, outc_reg};
                `FPD_LINE_OFF: readdata <= {24'h0, bidir_in};
                `FPD_FUNC_OFF: readdata <= {28'h0, func_reg};
                `FPD_OUTB_OFF: readdata <= {24'h0, outb_reg};
                `FPD_TEST_OFF: readdata <= {31'h0, test_reg};
                `FPD_INS_OFF: readdata <= {24'h0, standard_input_port};
                `FPD_ANA_OFF: readdata <= {25'h0, fixed_ana_in, ana_port_in};
                default: response <= 2'h2; // unmapped: slave error
            endcase
        end
    end
endmodule

/* fpd_pin_config_props.sv */
// checker for the five-port pin block: bus handshake and pin relations
// assumes it is bound to fpd_pin_config and sees only its ports
`include "fpd_params.svh"
module fpd_pin_config_props (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic waitrequest,
    input wire logic [1:0] response,
    input wire logic [7:0] bidir_oe,
    input wire logic [7:0] bidir_out,
    input wire logic [7:0] bidir_in,
    input wire logic [7:0] fixed_output_port,
    input wire logic [7:0] standard_input_port,
    input wire logic ir_rx,
    input wire logic kbd_clk,
    input wire logic kbd_data,
    input wire logic [2:0] fixed_ana_mode,
    input wire logic scl_in,
    input wire logic sda_in
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic wr_ok;
    logic [6:0] dir_age;
    logic [7:0] dir_want;
    assign wr_ok = write && !waitrequest && byteenable[0]; // lane 0 write lands here
    // age of the last direction write; saturates so the check fires once per write
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dir_age <= 7'h7f;
            dir_want <= 8'h00;
        end else if (wr_ok && (address == `FPD_DIRS_OFF || address == `FPD_TRIS_OFF)) begin
            dir_age <= 7'h00;
            dir_want <= address[2] ? ~writedata[7:0] : writedata[7:0];
        end else if (dir_age != 7'h7f) begin
            dir_age <= dir_age + 7'h01;
        end
    end
    chk_wait_pulse: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_req_answer: assert property ((read || write) && waitrequest |-> ##[1:2] !waitrequest)
        else $error("request not answered");
    chk_bad_addr: assert property (!waitrequest && (read || write) && address > 8'h20
        |-> response == 2'b10) else $error("unmapped access not refused");
    chk_reset_pins: assert property ($rose(rst_n)
        |-> {bidir_oe, bidir_out, fixed_output_port} == 24'h0) else $error("pins not reset");
    chk_ana_fixed: assert property (fixed_ana_mode == 3'b111)
        else $error("fixed analogue lines changed mode");
    chk_std_copy: assert property ($past(rst_n) |-> {kbd_data, kbd_clk, ir_rx} ==
        {$past(standard_input_port[7:6]), $past(standard_input_port[0])})
        else $error("shared input functions do not follow the input port");
    chk_i2c_copy: assert property ($past(rst_n)
        |-> {sda_in, scl_in} == $past(bidir_in[4:3])) else $error("i2c inputs wrong");
    chk_dir_settle: assert property (dir_age == 7'd66 |-> bidir_oe == dir_want)
        else $error("direction not applied after refresh");
    cover property (wr_ok && address == `FPD_TRIS_OFF);
    cover property (dir_age == 7'd66);
    cover property (response == 2'b10 && !waitrequest);
endmodule

bind fpd_pin_config fpd_pin_config_props chk (.core_clk, .rst_n, .address, .read, .write,
    .writedata, .byteenable, .waitrequest, .response, .bidir_oe, .bidir_out, .bidir_in,
    .fixed_output_port, .standard_input_port, .ir_rx, .kbd_clk, .kbd_data, .fixed_ana_mode,
    .scl_in, .sda_in);

/* fpd_board.sv */
// board model: switches on the two-way port lines
// assumes the bench sets switch levels; a driven line shows its driver
module fpd_board (
    input wire logic [7:0] sw,
    input wire logic [7:0] oe,
    input wire logic [7:0] drv,
    output logic [7:0] pin
);
    // a driven line overrides its switch, an undriven one shows the switch
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin[i] = oe[i] ? drv[i] : sw[i];
        end
    end
endmodule

/* fpd_pin_config_test.sv */
// self-checking bench for fpd_pin_config with a board model on the two-way port
// assumes one clock; the bench plays the firmware on the register bus
`include "fpd_params.svh"
module fpd_pin_config_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0;
    logic pwm1_in = 1'b0, pwm2_in = 1'b0, scl_out = 1'b1, sda_out = 1'b1;
    logic [7:0] address = 8'h00, sw = 8'h00, standard_input_port = 8'h00, pins;
    logic [31:0] writedata = 32'h0, rdata, readdata;
    logic [3:0] ana_port_in = 4'h0;
    logic [3:0] byteenable = 4'hf;
    logic [2:0] fixed_ana_in = 3'h0, fixed_ana_mode;
    logic [1:0] response, resp;
    logic [7:0] bidir_out, bidir_oe, bidir_in, fixed_output_port;
    logic waitrequest, ana_port_digital, ir_rx, kbd_clk, kbd_data, scl_in, sda_in;
    int error_cnt = 0, n_tests = 0, cycles = 0, m_dirs, m_out, v, p, mask, hit;

    fpd_pin_config dut (.core_clk, .rst_n, .address, .read, .write, .writedata,
        .byteenable, .readdata, .waitrequest, .response, .ana_port_in, .ana_port_digital,
        .fixed_output_port, .bidir_in, .bidir_out, .bidir_oe, .standard_input_port, .ir_rx,
        .kbd_clk, .kbd_data, .fixed_ana_in, .fixed_ana_mode, .pwm1_in, .pwm2_in, .scl_out,
        .sda_out, .scl_in, .sda_in);
    fpd_board board (.sw(sw), .oe(bidir_oe), .drv(bidir_out), .pin(bidir_in));

    // ----------------------------------------
    // clock, hang guard and helpers
    // ----------------------------------------
    always #2 core_clk = ~core_clk;
    // the sequence needs a little over a thousand cycles; far beyond that it has hung
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one transfer, held until waitrequest is sampled low, then one idle cycle
    task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        read <= rd;
        write <= !rd;
        address <= a;
        writedata <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 40);
        error_cnt += (n == 40);
        rdata = readdata;
        resp = response;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h21193a8d));
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        check("reset", {bidir_oe, fixed_output_port, ana_port_digital, fixed_ana_mode},
            {17'h0, 3'h7});
        // direction bytes through both polarities; the first is all outputs
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 255 : $urandom_range(0, 255);
            bus(1'b0, i[0] ? `FPD_TRIS_OFF : `FPD_DIRS_OFF, 32'(v));
            m_dirs = i[0] ? ~v & 255 : v;
            repeat (70) @(posedge core_clk);
            check("oe", bidir_oe, m_dirs);
            bus(1'b1, i[0] ? `FPD_TRIS_OFF : `FPD_DIRS_OFF, 32'h0);
            check("dirs", rdata, i[0] ? v : m_dirs);
        end
        // a write with byte lane 0 off is dropped
        byteenable <= 4'h0;
        bus(1'b0, `FPD_DIRS_OFF, 32'(~m_dirs));
        byteenable <= 4'hf;
        bus(1'b1, `FPD_DIRS_OFF, 32'h0);
        check("lane", rdata, m_dirs);
        // latch written while lines are inputs must show once they drive
        bus(1'b0, `FPD_DIRS_OFF, 32'h0);
        repeat (70) @(posedge core_clk);
        m_out = $urandom_range(0, 255);
        bus(1'b0, `FPD_OUTC_OFF, 32'(m_out));
        @(posedge core_clk);
        check("latch", {bidir_oe, bidir_out}, m_out);
        bus(1'b0, `FPD_DIRS_OFF, 32'hff);
        repeat (70) @(posedge core_clk);
        check("latch", {bidir_oe, bidir_out}, 32'hff00 | m_out);
        for (int i = 1; i >= 0; i--) begin
            m_out = i ? 255 : 0;
            bus(1'b0, `FPD_OUTC_OFF, 32'(m_out));
            @(posedge core_clk);
            check("out", bidir_out, m_out);
        end
        // single line drives: direction and level both land
        bus(1'b0, `FPD_DIRS_OFF, 32'h0);
        m_dirs = 0;
        repeat (70) @(posedge core_clk);
        for (int i = 0; i < 4; i++) begin
            v = $urandom_range(0, 31) & 'h17;
            bus(1'b0, `FPD_LINE_OFF, 32'(v));
            m_dirs |= 1 << v[2:0];
            m_out = (m_out & ~(1 << v[2:0])) | (v[4] << v[2:0]);
            repeat (70) @(posedge core_clk);
            check("line", {bidir_oe, bidir_out}, {m_dirs[7:0], m_out[7:0]});
        end
        v = $urandom_range(0, 255);
        bus(1'b0, `FPD_OUTB_OFF, 32'(v));
        bus(1'b0, `FPD_DIRS_OFF, 32'h0);
        m_dirs = 0;
        repeat (70) @(posedge core_clk);
        check("outb", fixed_output_port, v);
        // level tests on the standard, analogue and two-way ports, any and all matches
        bus(1'b0, `FPD_FUNC_OFF, 32'h8);
        @(posedge core_clk);
        check("digital", ana_port_digital, 1);
        for (int i = 0; i < 8; i++) begin
            standard_input_port <= 8'($urandom);
            ana_port_in <= 4'($urandom);
            fixed_ana_in <= 3'($urandom);
            sw <= 8'($urandom);
            p = i % 4;
            mask = $urandom_range(1, (p == 1) ? 15 : 255);
            v = $urandom_range(0, 255);
            bus(1'b0, `FPD_TEST_OFF, {13'h0, i[2], p[1:0], v[7:0], mask[7:0]});
            bus(1'b1, `FPD_TEST_OFF, 32'h0);
            pins = (p == 0) ? standard_input_port : (p == 1) ? {4'h0, ana_port_in} : sw;
            hit = ~(pins ^ v) & mask;
            hit = (p == 3) ? 0 : i[2] ? (hit == mask) : (hit != 0);
            check("test", rdata[0], hit);
            check("shared", {kbd_data, kbd_clk, ir_rx},
                {standard_input_port[7:6], standard_input_port[0]});
            bus(1'b1, `FPD_ANA_OFF, 32'h0);
            check("ana", rdata, {fixed_ana_in, ana_port_in});
        end
        // pwm sources on lines 1 and 2, then open-drain i2c on lines 3 and 4
        bus(1'b0, `FPD_FUNC_OFF, 32'h3);
        for (int i = 0; i < 4; i++) begin
            pwm1_in <= i[0];
            pwm2_in <= i[1];
            repeat (3) @(posedge core_clk);
            check("pwm", {bidir_oe[2:1], bidir_out[2:1]}, {2'b11, i[1:0]});
        end
        bus(1'b0, `FPD_FUNC_OFF, 32'h4);
        for (int i = 0; i < 4; i++) begin
            scl_out <= i[0];
            sda_out <= i[1];
            repeat (3) @(posedge core_clk);
            check("i2c", {bidir_oe[4:3], bidir_out[4:3]}, {~i[1:0], 2'b00});
            check("i2c in", {sda_in, scl_in}, {i[1] & sw[4], i[0] & sw[3]});
        end
        bus(1'b1, 8'h40, 32'h0);
        check("resp", {resp, rdata}, {2'b10, 32'h0});
        conclude();
    end
endmodule
